// File: inc/cpf_pkg.sv
// Shared constants and carrier types of the charger protection monitor.
package cpf_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_MHZ         = 200;
	localparam int unsigned EVENT_PULSE_US  = 256;
	localparam int unsigned EVENT_PULSE_CYC = EVENT_PULSE_US * CLK_MHZ;
	localparam int unsigned SOFT_START_US   = 100;
	localparam int unsigned SOFT_START_CYC  = SOFT_START_US * CLK_MHZ;
	localparam int unsigned HICCUP_OFF_US   = 100;
	localparam int unsigned HICCUP_OFF_CYC  = HICCUP_OFF_US * CLK_MHZ;
	localparam int unsigned TIMER_TICK_US   = 1000;
	localparam int unsigned TIMER_TICK_CYC  = TIMER_TICK_US * CLK_MHZ;
	localparam logic [2:0]  HICCUP_RETRIES  = 3'h7;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [11:0] CTRL_OFS   = 12'h000;
	localparam logic [11:0] FAULT_OFS  = 12'h004;
	localparam logic [11:0] STATUS_OFS = 12'h008;

	localparam int CTRL_OVSEL_LSB  = 0;
	localparam int CTRL_BOOST_BIT  = 2;
	localparam int CTRL_PRECH_LSB  = 3;
	localparam int CTRL_SHIPX_BIT  = 7;
	localparam logic [1:0] OVSEL_RESET = 2'h1;
	localparam logic [3:0] PRECH_RESET = 4'h3;

	localparam int FAULT_CODE_LSB  = 0;
	localparam int FAULT_BOOST_BIT = 2;
	localparam int FAULT_BATOV_BIT = 3;

	localparam int STAT_THERM_BIT  = 0;
	localparam int STAT_BATSW_BIT  = 1;
	localparam int STAT_DEPL_BIT   = 2;
	localparam int STAT_OCL_BIT    = 3;
	localparam int STAT_HICC_BIT   = 4;
	localparam int STAT_RETRY_LSB  = 5;

	// ****************************************************************
	// Encodings
	// ****************************************************************
	localparam logic [1:0] CODE_NONE  = 2'h0;
	localparam logic [1:0] CODE_INPOV = 2'h1;
	localparam logic [1:0] CODE_TSHUT = 2'h2;

	localparam logic [1:0] CUR_OFF   = 2'h0;
	localparam logic [1:0] CUR_SHORT = 2'h1;
	localparam logic [1:0] CUR_PRECH = 2'h2;
	localparam logic [1:0] CUR_FAST  = 2'h3;

	localparam int SENSE_W = 14;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic input_overvoltage;
		logic input_ov_below_hyst;
		logic system_overvoltage;
		logic boost_short;
		logic boost_output_ov;
		logic temp_over_reg;
		logic temp_over_shut;
		logic temp_below_hyst;
		logic battery_overvoltage;
		logic battery_depleted;
		logic battery_below_short;
		logic battery_below_low;
		logic battery_switch_oc;
		logic input_valid;
	} cpf_sense_type;

	typedef struct packed {
		logic       converter_halt;
		logic       system_sink_en;
		logic       boost_run;
		logic       boost_soft_start;
		logic       reverse_block_switch_q;
		logic       battery_switch;
		logic       charge_enable;
		logic       direct_charge_en;
		logic       thermal_reduce;
		logic       term_inhibit;
		logic [1:0] charge_current_mode;
		logic [3:0] precharge_current_sel;
		logic [1:0] input_ov_threshold_sel;
	} cpf_power_type;

	typedef struct packed {
		logic [1:0] charge_fault_code;
		logic       boost_fault;
		logic       battery_ov_flag;
	} cpf_fault_type;

	typedef enum logic [2:0] {
		BST_OFF,
		BST_SOFT,
		BST_RUN,
		BST_HICCUP
	} cpf_boost_type;

endpackage

// File: verilog/cpf_sync.sv
// Two-stage synchroniser for a group of comparator levels.
`timescale 1ns/1ps

module cpf_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// File: verilog/cpf_event_pulse.sv
// Fixed-width active-low pulse generator for host events.
`timescale 1ns/1ps

module cpf_event_pulse #(
	parameter int unsigned LEN = 51200
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Event in, pulse out
	input  wire logic event_in,
	output logic      pulse_n
);

	logic [31:0] cnt_r;

	// Events during a running pulse merge into it, so the host sees one low.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cnt_r   <= 32'h0;
			pulse_n <= 1'b1;
		end
		else if (cnt_r != 32'h0)
		begin
			cnt_r   <= cnt_r - 32'h1;
			pulse_n <= (cnt_r == 32'h1);
		end
		else if (event_in)
		begin
			cnt_r   <= LEN;
			pulse_n <= 1'b0;
		end
	end

	property p_pulse_len;
		@(posedge clk) disable iff (reset)
		$fell(pulse_n) |-> (cnt_r == LEN) ##1 !pulse_n [*8];
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("event pulse shorter than expected");

endmodule

// File: verilog/cpf_monitor.sv
// Protection and fault monitor of a buck/boost single-cell charger.
`timescale 1ns/1ps

// Summary of operation
// - Halt switching when input exceeds selected over-voltage threshold; selector default 6.5V.
// - Each rise of input over-voltage produces one host event.
// - Charge fault code reads 01 while input over-voltage persists, unless buck thermal shutdown sets 10.
// - Code returns to 00 only after hysteresis clearance and a fault read.
// - Charging resumes by itself when input over-voltage deasserts.
// - System over-voltage stops switching and enables the system sink.
// - Every boost enable starts with a soft-start phase.
// - Boost short opens reverse-blocking switch and retries hiccup-style, seven times.
// - Short after all retries clears boost enable, sets boost fault, raises event.
// - Host re-enabling boost clears the boost fault flag.
// - Boost output over-voltage stops, clears enable, sets boost fault, raises event.
// - Buck thermal regulation reduces current and sets the regulation flag.
// - During thermal regulation safety timer runs half rate, termination inhibited.
// - Buck thermal shutdown halts converter, code 10, raises event.
// - Buck converter restarts after temperature falls below hysteresis band.
// - Boost shutdown opens battery switch, clears enable; switch returns after hysteresis.
// - Battery over-voltage stops charging and direct charging, sets flag, event.
// - Battery depletion opens battery switch, latched until valid input appears.
// - Recovery charges at short current, then precharge between thresholds.
// - Battery switch over-current latches switch off until ship-mode exit.
// - Each host event is one active-low 256us pulse.
// - Fault read returns history first, live faults on the following read.

module cpf_monitor #(
	parameter int unsigned EVENT_CYC  = cpf_pkg::EVENT_PULSE_CYC,
	parameter int unsigned SOFT_CYC   = cpf_pkg::SOFT_START_CYC,
	parameter int unsigned HICCUP_CYC = cpf_pkg::HICCUP_OFF_CYC,
	parameter int unsigned TICK_CYC   = cpf_pkg::TIMER_TICK_CYC
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Analog comparators
	input  wire cpf_pkg::cpf_sense_type sense,
	// Power stage control
	output cpf_pkg::cpf_power_type      power,
	output logic                        safety_tick,
	// Host event line
	output logic                        host_event_pulse_n
);

	// ****************************************************************
	// Synchronised indications
	// ****************************************************************
	cpf_pkg::cpf_sense_type s;

	cpf_sync #(
		.W (cpf_pkg::SENSE_W)
	) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     (sense),
		.q     (s)
	);

	// ****************************************************************
	// Register bus
	// ****************************************************************
	logic [1:0]          input_ov_threshold_sel_r;
	logic                boost_enable_bit_r;
	logic [3:0]          precharge_current_sel_r;
	cpf_pkg::cpf_fault_type live;
	cpf_pkg::cpf_fault_type hist_r;
	cpf_pkg::cpf_boost_type bst_r;
	logic [2:0]          retry_r;
	logic                thermal_regulation_flag_r;
	logic                depleted_r;
	logic                oc_latch_r;
	logic                boost_tshut_r;
	logic                buck_tshut_r;
	logic                iov_hold_r;
	logic                boost_fault_r;
	logic                boost_fault_set;
	logic                boost_hw_clear;
	logic [31:0]         rd_nxt;
	logic                wr_done;
	logic                fault_read;
	logic                boost_en_wr;
	logic                ship_exit;

	assign wr_done     = psel & penable & pready & pwrite;
	assign fault_read  = psel & penable & pready & !pwrite
		& (paddr == cpf_pkg::FAULT_OFS);
	assign boost_en_wr = wr_done & (paddr == cpf_pkg::CTRL_OFS)
		& pwdata[cpf_pkg::CTRL_BOOST_BIT];
	assign ship_exit   = wr_done & (paddr == cpf_pkg::CTRL_OFS)
		& pwdata[cpf_pkg::CTRL_SHIPX_BIT];

	always_comb
	begin
		rd_nxt = 32'h0;
		case (paddr)
			cpf_pkg::CTRL_OFS:
			begin
				rd_nxt[cpf_pkg::CTRL_OVSEL_LSB +: 2] = input_ov_threshold_sel_r;
				rd_nxt[cpf_pkg::CTRL_BOOST_BIT]      = boost_enable_bit_r;
				rd_nxt[cpf_pkg::CTRL_PRECH_LSB +: 4] = precharge_current_sel_r;
			end
			cpf_pkg::FAULT_OFS:
			begin
				rd_nxt[cpf_pkg::FAULT_CODE_LSB +: 2] = hist_r.charge_fault_code;
				rd_nxt[cpf_pkg::FAULT_BOOST_BIT]     = hist_r.boost_fault;
				rd_nxt[cpf_pkg::FAULT_BATOV_BIT]     = hist_r.battery_ov_flag;
			end
			cpf_pkg::STATUS_OFS:
			begin
				rd_nxt[cpf_pkg::STAT_THERM_BIT] = thermal_regulation_flag_r;
				rd_nxt[cpf_pkg::STAT_BATSW_BIT] = power.battery_switch;
				rd_nxt[cpf_pkg::STAT_DEPL_BIT]  = depleted_r;
				rd_nxt[cpf_pkg::STAT_OCL_BIT]   = oc_latch_r;
				rd_nxt[cpf_pkg::STAT_HICC_BIT]  = (bst_r == cpf_pkg::BST_HICCUP);
				rd_nxt[cpf_pkg::STAT_RETRY_LSB +: 3] = retry_r;
			end
			default:
			begin
				rd_nxt = 32'h0;
			end
		endcase
	end

	// Data are captured in the setup cycle so the access completes at once.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata  <= rd_nxt;
			pready  <= psel & !penable;
			pslverr <= psel & !penable & (paddr != cpf_pkg::CTRL_OFS)
				& (paddr != cpf_pkg::FAULT_OFS)
				& (paddr != cpf_pkg::STATUS_OFS);
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			input_ov_threshold_sel_r <= cpf_pkg::OVSEL_RESET;
			precharge_current_sel_r  <= cpf_pkg::PRECH_RESET;
		end
		else if (wr_done & (paddr == cpf_pkg::CTRL_OFS))
		begin
			input_ov_threshold_sel_r <= pwdata[cpf_pkg::CTRL_OVSEL_LSB +: 2];
			precharge_current_sel_r  <= pwdata[cpf_pkg::CTRL_PRECH_LSB +: 4];
		end
	end

	// A fault clear in hardware beats a host write in the same cycle.
	always_ff @(posedge clk)
	begin
		if (reset)
			boost_enable_bit_r <= 1'b0;
		else if (boost_hw_clear)
			boost_enable_bit_r <= 1'b0;
		else if (wr_done & (paddr == cpf_pkg::CTRL_OFS))
			boost_enable_bit_r <= pwdata[cpf_pkg::CTRL_BOOST_BIT];
	end

	// ****************************************************************
	// Boost sequencing
	// ****************************************************************
	logic [31:0] bst_cnt_r;
	logic        boost_ov_stop;

	assign boost_ov_stop  = s.boost_output_ov & ((bst_r == cpf_pkg::BST_SOFT)
		| (bst_r == cpf_pkg::BST_RUN));
	assign boost_fault_set = boost_ov_stop | (s.boost_short
		& ((bst_r == cpf_pkg::BST_SOFT) | (bst_r == cpf_pkg::BST_RUN))
		& (retry_r == cpf_pkg::HICCUP_RETRIES));
	assign boost_hw_clear = boost_fault_set | (s.temp_over_shut
		& (bst_r != cpf_pkg::BST_OFF));

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			bst_r     <= cpf_pkg::BST_OFF;
			bst_cnt_r <= 32'h0;
			retry_r   <= 3'h0;
		end
		else if (boost_hw_clear | !boost_enable_bit_r)
		begin
			bst_r     <= cpf_pkg::BST_OFF;
			bst_cnt_r <= 32'h0;
		end
		else
		begin
			case (bst_r)
				cpf_pkg::BST_OFF:
				begin
					bst_r     <= cpf_pkg::BST_SOFT;
					bst_cnt_r <= SOFT_CYC;
					retry_r   <= 3'h0;
				end
				cpf_pkg::BST_SOFT, cpf_pkg::BST_RUN:
				begin
					if (s.boost_short)
					begin
						bst_r     <= cpf_pkg::BST_HICCUP;
						bst_cnt_r <= HICCUP_CYC;
					end
					else if (bst_cnt_r != 32'h0)
						bst_cnt_r <= bst_cnt_r - 32'h1;
					else
						bst_r <= cpf_pkg::BST_RUN;
				end
				cpf_pkg::BST_HICCUP:
				begin
					if (bst_cnt_r != 32'h0)
						bst_cnt_r <= bst_cnt_r - 32'h1;
					else
					begin
						retry_r   <= retry_r + 3'h1;
						bst_r     <= cpf_pkg::BST_SOFT;
						bst_cnt_r <= SOFT_CYC;
					end
				end
				default:
				begin
					bst_r <= cpf_pkg::BST_OFF;
				end
			endcase
		end
	end

	// ****************************************************************
	// Fault state
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (reset)
			boost_fault_r <= 1'b0;
		else if (boost_fault_set)
			boost_fault_r <= 1'b1;
		else if (boost_en_wr)
			boost_fault_r <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			iov_hold_r    <= 1'b0;
			buck_tshut_r  <= 1'b0;
			boost_tshut_r <= 1'b0;
		end
		else
		begin
			if (s.input_overvoltage)
				iov_hold_r <= 1'b1;
			else if (s.input_ov_below_hyst)
				iov_hold_r <= 1'b0;
			if (s.temp_over_shut & !boost_enable_bit_r)
				buck_tshut_r <= 1'b1;
			else if (s.temp_below_hyst)
				buck_tshut_r <= 1'b0;
			if (s.temp_over_shut & boost_enable_bit_r)
				boost_tshut_r <= 1'b1;
			else if (s.temp_below_hyst)
				boost_tshut_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			depleted_r <= 1'b0;
			oc_latch_r <= 1'b0;
		end
		else
		begin
			if (s.battery_depleted)
				depleted_r <= 1'b1;
			else if (s.input_valid)
				depleted_r <= 1'b0;
			if (s.battery_switch_oc)
				oc_latch_r <= 1'b1;
			else if (ship_exit)
				oc_latch_r <= 1'b0;
		end
	end

	always_comb
	begin
		live.charge_fault_code = buck_tshut_r ? cpf_pkg::CODE_TSHUT
			: iov_hold_r ? cpf_pkg::CODE_INPOV : cpf_pkg::CODE_NONE;
		live.boost_fault       = boost_fault_r;
		live.battery_ov_flag   = s.battery_overvoltage;
	end

	// History keeps the worst code since the last read; the read reloads it.
	always_ff @(posedge clk)
	begin
		if (reset)
			hist_r <= '0;
		else if (fault_read)
			hist_r <= live;
		else
		begin
			if ((live.charge_fault_code == cpf_pkg::CODE_TSHUT)
				| (hist_r.charge_fault_code == cpf_pkg::CODE_NONE))
				hist_r.charge_fault_code <= live.charge_fault_code;
			hist_r.boost_fault     <= hist_r.boost_fault | live.boost_fault;
			hist_r.battery_ov_flag <= hist_r.battery_ov_flag
				| live.battery_ov_flag;
		end
	end

	// ****************************************************************
	// Events
	// ****************************************************************
	logic iov_d_r;
	logic tshut_d_r;
	logic batov_d_r;
	logic event_any;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			iov_d_r   <= 1'b0;
			tshut_d_r <= 1'b0;
			batov_d_r <= 1'b0;
		end
		else
		begin
			iov_d_r   <= s.input_overvoltage;
			tshut_d_r <= buck_tshut_r;
			batov_d_r <= s.battery_overvoltage;
		end
	end

	assign event_any = (s.input_overvoltage & !iov_d_r)
		| (buck_tshut_r & !tshut_d_r)
		| (s.battery_overvoltage & !batov_d_r)
		| boost_fault_set;

	cpf_event_pulse #(
		.LEN (EVENT_CYC)
	) u_pulse (
		.clk      (clk),
		.reset    (reset),
		.event_in (event_any),
		.pulse_n  (host_event_pulse_n)
	);

	// ****************************************************************
	// Power stage outputs
	// ****************************************************************
	logic [31:0] tick_cnt_r;
	logic        half_r;
	logic        therm_nxt;

	assign therm_nxt = s.temp_over_reg & !boost_enable_bit_r;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tick_cnt_r  <= 32'h0;
			half_r      <= 1'b0;
			safety_tick <= 1'b0;
			thermal_regulation_flag_r <= 1'b0;
		end
		else
		begin
			thermal_regulation_flag_r <= therm_nxt;
			tick_cnt_r  <= (tick_cnt_r == TICK_CYC - 1) ? 32'h0
				: tick_cnt_r + 32'h1;
			if (tick_cnt_r == TICK_CYC - 1)
				half_r <= !half_r;
			safety_tick <= (tick_cnt_r == TICK_CYC - 1)
				& (!thermal_regulation_flag_r | half_r);
		end
	end

	// The input hold latch is not used here, so charging restarts on release.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			power <= '0;
			power.input_ov_threshold_sel <= cpf_pkg::OVSEL_RESET;
			power.precharge_current_sel  <= cpf_pkg::PRECH_RESET;
		end
		else
		begin
			power.converter_halt <= s.input_overvoltage
				| s.system_overvoltage | buck_tshut_r | boost_ov_stop;
			power.system_sink_en   <= s.system_overvoltage;
			power.boost_run        <= (bst_r == cpf_pkg::BST_SOFT)
				| (bst_r == cpf_pkg::BST_RUN);
			power.boost_soft_start <= (bst_r == cpf_pkg::BST_SOFT);
			power.reverse_block_switch_q <= (bst_r != cpf_pkg::BST_HICCUP);
			power.battery_switch   <= !(boost_tshut_r | depleted_r
				| oc_latch_r);
			power.charge_enable    <= !(s.battery_overvoltage
				| s.input_overvoltage | buck_tshut_r | boost_enable_bit_r);
			power.direct_charge_en <= !s.battery_overvoltage;
			power.thermal_reduce   <= therm_nxt;
			power.term_inhibit     <= therm_nxt;
			power.charge_current_mode <= s.battery_below_short
				? cpf_pkg::CUR_SHORT : s.battery_below_low
				? cpf_pkg::CUR_PRECH : cpf_pkg::CUR_FAST;
			power.precharge_current_sel  <= precharge_current_sel_r;
			power.input_ov_threshold_sel <= input_ov_threshold_sel_r;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_iov_halt;
		@(posedge clk) disable iff (reset)
		s.input_overvoltage |=> power.converter_halt;
	endproperty
	a_iov_halt: assert property (p_iov_halt)
		else $error("input over-voltage did not halt converter");

	property p_iov_code;
		@(posedge clk) disable iff (reset)
		(s.input_overvoltage & !buck_tshut_r) |=>
			(live.charge_fault_code == cpf_pkg::CODE_INPOV) | buck_tshut_r;
	endproperty
	a_iov_code: assert property (p_iov_code)
		else $error("input over-voltage code missing");

	property p_code_hold;
		@(posedge clk) disable iff (reset)
		(hist_r.charge_fault_code == cpf_pkg::CODE_INPOV) & !fault_read
			|=> hist_r.charge_fault_code != cpf_pkg::CODE_NONE;
	endproperty
	a_code_hold: assert property (p_code_hold)
		else $error("fault code cleared without a read");

	property p_sysov;
		@(posedge clk) disable iff (reset)
		s.system_overvoltage |=> power.system_sink_en & power.converter_halt;
	endproperty
	a_sysov: assert property (p_sysov)
		else $error("system over-voltage not handled");

	property p_soft;
		@(posedge clk) disable iff (reset)
		(bst_r == cpf_pkg::BST_OFF) ##1 (bst_r != cpf_pkg::BST_OFF)
			|-> (bst_r == cpf_pkg::BST_SOFT);
	endproperty
	a_soft: assert property (p_soft)
		else $error("boost started without soft-start");

	property p_boost_fault;
		@(posedge clk) disable iff (reset)
		boost_fault_set |=> boost_fault_r & !boost_enable_bit_r
			& (bst_r == cpf_pkg::BST_OFF);
	endproperty
	a_boost_fault: assert property (p_boost_fault)
		else $error("boost fault not latched");

	property p_boost_ev;
		@(posedge clk) disable iff (reset)
		boost_fault_set & host_event_pulse_n & (u_pulse.cnt_r == 32'h0)
			|=> !host_event_pulse_n;
	endproperty
	a_boost_ev: assert property (p_boost_ev)
		else $error("boost fault raised no event");

	property p_tshut;
		@(posedge clk) disable iff (reset)
		$rose(buck_tshut_r) |-> live.charge_fault_code == cpf_pkg::CODE_TSHUT
			##1 power.converter_halt;
	endproperty
	a_tshut: assert property (p_tshut)
		else $error("thermal shutdown not reported");

	property p_batsw;
		@(posedge clk) disable iff (reset)
		$rose(oc_latch_r) |=> !power.battery_switch [*2];
	endproperty
	a_batsw: assert property (p_batsw)
		else $error("battery switch not opened on over-current");

	c_hiccup: cover property (@(posedge clk) disable iff (reset)
		bst_r == cpf_pkg::BST_HICCUP);
	c_fault_read: cover property (@(posedge clk) disable iff (reset)
		fault_read & (hist_r.charge_fault_code != cpf_pkg::CODE_NONE));
	c_therm: cover property (@(posedge clk) disable iff (reset)
		$rose(thermal_regulation_flag_r));

endmodule

// File: verif/cpf_sensor_model.sv
// Comparator model that feeds the monitor its analog indications.
`timescale 1ns/1ps

module cpf_sensor_model (
	// Clock
	input  wire logic                   clk,
	// Wanted levels and power stage state
	input  wire cpf_pkg::cpf_sense_type want,
	input  wire cpf_pkg::cpf_power_type power,
	// Comparator outputs
	output cpf_pkg::cpf_sense_type      sense
);
	// A short only draws current while the reverse switch conducts.
	always_ff @(posedge clk)
	begin
		sense <= want;
		sense.boost_short <= want.boost_short & power.reverse_block_switch_q;
	end
endmodule

// File: verif/cpf_monitor_tb.sv
// Self-checking testbench of the charger protection monitor.
`timescale 1ns/1ps

module charger_protection_fault_monitor_tb_top;
	logic                   clk, reset, psel, penable, pwrite, err;
	logic                   pready, pslverr, safety_tick, host_event_pulse_n;
	logic [11:0]            paddr;
	logic [31:0]            pwdata, prdata, rd, seed;
	cpf_pkg::cpf_sense_type want, sense, w;
	cpf_pkg::cpf_power_type power;
	int                     miscompares, compares, lows, ticks;

	cpf_sensor_model sm (.clk(clk), .want(want), .power(power), .sense(sense));
	cpf_monitor #(.EVENT_CYC(20), .SOFT_CYC(10), .HICCUP_CYC(10),
		.TICK_CYC(8)) uut (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
		.power(power), .safety_tick(safety_tick),
		.host_event_pulse_n(host_event_pulse_n));

	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk)
		if (host_event_pulse_n === 1'b0)
			lows++;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask

	// Whole APB transfer; the request stands until pready is seen.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(0, a, 0);
		check(rd & m, e);
	endtask

	function automatic logic [31:0] xorshift(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction

	task count_ticks;
		ticks = 0;
		repeat (64)
		begin
			@(posedge clk);
			ticks += safety_tick;
		end
	endtask

	task settle;
		repeat (6) @(posedge clk);
	endtask

	task give_verdict;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		repeat (3000) @(posedge clk);
		miscompares++;
		give_verdict;
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		reset = 1;
		want = '0;
		seed = 32'hEB83;
		repeat (4) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		rdchk(12'h000, 32'hFF, 32'h19);
		apb(0, 12'h0FC, 0);
		check({31'h0, err}, 32'h1);
		repeat (4)
		begin
			seed = xorshift(seed);
			apb(1, 12'h000, {25'h0, seed[5:2], 1'b0, seed[1:0]});
			settle;
			check(power.input_ov_threshold_sel, seed[1:0]);
			check(power.precharge_current_sel, seed[5:2]);
		end
		$display("selector test done");
		lows = 0;
		want.input_overvoltage <= 1;
		settle;
		check(power.converter_halt, 1);
		repeat (30) @(posedge clk);
		check(lows, 20);
		rdchk(12'h004, 32'h3, 32'h1);
		want.input_overvoltage <= 0;
		settle;
		check(power.converter_halt, 0);
		rdchk(12'h004, 32'h3, 32'h1);
		want.input_ov_below_hyst <= 1;
		settle;
		rdchk(12'h004, 32'h3, 32'h1);
		rdchk(12'h004, 32'h3, 32'h0);
		$display("input over-voltage test done");
		w = '0;
		w.temp_over_shut = 1;
		w.input_overvoltage = 1;
		w.battery_overvoltage = 1;
		want <= w;
		settle;
		check(power.charge_enable, 0);
		check(power.direct_charge_en, 0);
		rdchk(12'h004, 32'hB, 32'hA);
		rdchk(12'h004, 32'hB, 32'hA);
		w = '0;
		w.temp_below_hyst = 1;
		w.input_ov_below_hyst = 1;
		want <= w;
		settle;
		check(power.converter_halt, 0);
		$display("thermal test done");
		apb(1, 12'h000, 32'h1D);
		repeat (2) @(posedge clk);
		check(power.boost_soft_start, 1);
		check(power.boost_run, 1);
		want.boost_output_ov <= 1;
		settle;
		rdchk(12'h000, 32'h4, 32'h0);
		rdchk(12'h004, 32'h4, 32'h4);
		want.boost_output_ov <= 0;
		settle;
		apb(1, 12'h000, 32'h1D);
		rdchk(12'h004, 32'h4, 32'h4);
		rdchk(12'h004, 32'h4, 32'h0);
		$display("boost test done");
		lows = 0;
		want.boost_short <= 1;
		repeat (200) @(posedge clk);
		check(lows, 20);
		rdchk(12'h000, 32'h4, 32'h0);
		rdchk(12'h004, 32'h4, 32'h4);
		rdchk(12'h008, 32'hE0, 32'hE0);
		want.boost_short <= 0;
		settle;
		apb(1, 12'h000, 32'h1D);
		w = '0;
		w.temp_over_shut = 1;
		want <= w;
		settle;
		check(power.battery_switch, 0);
		rdchk(12'h000, 32'h4, 32'h0);
		w = '0;
		w.temp_below_hyst = 1;
		want <= w;
		settle;
		check(power.battery_switch, 1);
		rdchk(12'h000, 32'h4, 32'h0);
		$display("hiccup test done");
		w = '0;
		w.system_overvoltage = 1;
		w.battery_depleted = 1;
		w.battery_switch_oc = 1;
		w.battery_below_short = 1;
		w.temp_over_reg = 1;
		want <= w;
		settle;
		check(power.system_sink_en & power.converter_halt, 1);
		check(power.battery_switch, 0);
		check(power.charge_current_mode, cpf_pkg::CUR_SHORT);
		check(power.thermal_reduce & power.term_inhibit, 1);
		rdchk(12'h008, 32'h1, 32'h1);
		count_ticks;
		check(ticks, 4);
		w = '0;
		w.input_valid = 1;
		w.battery_below_low = 1;
		want <= w;
		settle;
		check(power.system_sink_en, 0);
		check(power.charge_current_mode, cpf_pkg::CUR_PRECH);
		rdchk(12'h008, 32'hF, 32'h8);
		count_ticks;
		check(ticks, 8);
		apb(1, 12'h000, 32'h99);
		settle;
		check(power.battery_switch, 1);
		$display("battery test done");
		give_verdict;
	end
endmodule
